// >>> spbt_pkg.sv
// Constants, types and a helper function for the split-port backplane transceiver
package spbt_pkg;

    localparam int          SPBT_CHANNELS    = 8;
    localparam int          SPBT_BUF_DEPTH   = 2;
    localparam int          SPBT_WB_DW       = 32;
    localparam int          SPBT_WB_AW       = 4;

    localparam logic [3:0]  SPBT_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  SPBT_ADDR_STATUS = 4'h4;

    localparam int          CTRL_OB_LO       = 0;
    localparam int          CTRL_OB_HI       = 1;
    localparam int          CTRL_IB_LO       = 2;
    localparam int          CTRL_IB_HI       = 3;
    localparam int          CTRL_RETURN      = 4;
    localparam int          CTRL_LOCAL_EN    = 5;
    localparam int          CTRL_BP_EN_HIGH  = 6;
    localparam int          CTRL_BP_EN_LOW   = 7;
    localparam int          CTRL_W           = 8;
    localparam logic [7:0]  CTRL_RESET       = 8'h80;

    localparam int          STAT_OB_LSB      = 0;
    localparam int          STAT_IB_LSB      = 8;
    localparam int          STAT_FULL        = 16;
    localparam int          STAT_EMPTY       = 17;

    typedef enum logic [1:0] {
        SPBT_BUFFER,
        SPBT_FLOP,
        SPBT_LATCH
    } spbt_mode_e;

    // Mode pair decode: 00 buffer, 01 flip-flop, 1x latch
    function automatic spbt_mode_e spbt_decode(input logic sel_hi, input logic sel_lo);
        spbt_mode_e m;
        m = SPBT_BUFFER;
        if (sel_hi) begin
            m = SPBT_LATCH;
        end else if (sel_lo) begin
            m = SPBT_FLOP;
        end
        return m;
    endfunction

endpackage

// >>> spbt_top.sv
// Eight-channel split-port to backplane transceiver datapath with Wishbone control
//
// Overview of operation
// - Eight channels, split local buses, shared backplane line
// - Each direction's element chosen by its mode pair
// - Buffer mode passes inverted input, no storage
// - Flip-flop mode captures on gate rising edge
// - Latch mode transparent while gate high, holds low
// - Return select low feeds inbound from backplane
// - Return select high feeds inbound from outbound element
// - Local enable high actively drives local output bus
// - Local enable low floats local output bus
// - Backplane outputs gated by high and low enables
// - Backplane drives only when high set, low clear
// - Both elements operate whatever the output enables
// - Disabled outputs still let elements accept or hold
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module spbt_top
    import spbt_pkg::*;
#(
    parameter int WIDTH = spbt_pkg::SPBT_CHANNELS,
    parameter int DEPTH = spbt_pkg::SPBT_BUF_DEPTH
) (
    input  wire logic                             MCLK,
    input  wire logic                             RST_N,
    input  wire logic                             WB_CYC_I,
    input  wire logic                             WB_STB_I,
    input  wire logic                             WB_WE_I,
    input  wire logic [spbt_pkg::SPBT_WB_AW-1:0]  WB_ADR_I,
    input  wire logic [3:0]                       WB_SEL_I,
    input  wire logic [spbt_pkg::SPBT_WB_DW-1:0]  WB_DAT_I,
    output logic      [spbt_pkg::SPBT_WB_DW-1:0]  WB_DAT_O,
    output logic                                  WB_ACK_O,
    input  wire logic [WIDTH-1:0]                 LOCAL_IN_BUS,
    output logic      [WIDTH-1:0]                 LOCAL_OUT_BUS,
    output logic      [WIDTH-1:0]                 LOCAL_OUT_OE_N,
    input  wire logic [WIDTH-1:0]                 BACKPLANE_I,
    output logic      [WIDTH-1:0]                 BACKPLANE_O,
    output logic      [WIDTH-1:0]                 BACKPLANE_OE_N,
    input  wire logic                             OUTBOUND_CLOCK_GATE,
    input  wire logic                             INBOUND_CLOCK_GATE,
    output logic                                  CAPTURE_IN_READY,
    output logic                                  CAPTURE_VALID,
    input  wire logic                             CAPTURE_READY,
    output logic      [WIDTH-1:0]                 CAPTURE_DATA
);
    import spbt_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (WIDTH < 1 || WIDTH > 8 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("spbt_top: WIDTH must be 1..8 and DEPTH a power of two of at least 2");
        end
    end

    // Pin synchronisers, three stages, accept when stages two and three agree
    logic [WIDTH-1:0] ai_s1_q, ai_s2_q, ai_s3_q, ai_v_q;
    logic [WIDTH-1:0] bp_s1_q, bp_s2_q, bp_s3_q, bp_v_q;
    logic [2:0]       og_s_q, ig_s_q;
    logic             og_v_q, ig_v_q, og_prev_q, ig_prev_q;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ai_s1_q <= '0; ai_s2_q <= '0; ai_s3_q <= '0; ai_v_q <= '0;
            bp_s1_q <= '1; bp_s2_q <= '1; bp_s3_q <= '1; bp_v_q <= '1;
            og_s_q <= 3'h0; ig_s_q <= 3'h0;
            og_v_q <= 1'b0; ig_v_q <= 1'b0; og_prev_q <= 1'b0; ig_prev_q <= 1'b0;
        end else begin
            ai_s1_q <= LOCAL_IN_BUS; ai_s2_q <= ai_s1_q; ai_s3_q <= ai_s2_q;
            bp_s1_q <= BACKPLANE_I;  bp_s2_q <= bp_s1_q; bp_s3_q <= bp_s2_q;
            og_s_q <= {og_s_q[1:0], OUTBOUND_CLOCK_GATE};
            ig_s_q <= {ig_s_q[1:0], INBOUND_CLOCK_GATE};
            if (ai_s2_q == ai_s3_q) ai_v_q <= ai_s3_q;
            if (bp_s2_q == bp_s3_q) bp_v_q <= bp_s3_q;
            if (og_s_q[1] == og_s_q[2]) og_v_q <= og_s_q[2];
            if (ig_s_q[1] == ig_s_q[2]) ig_v_q <= ig_s_q[2];
            og_prev_q <= og_v_q;
            ig_prev_q <= ig_v_q;
        end
    end

    // Control register
    logic [CTRL_W-1:0] ctrl_q;
    logic              ack_q;
    wire  bus_req   = WB_CYC_I & WB_STB_I & ~ack_q;
    wire  hit_ctrl  = (WB_ADR_I == SPBT_ADDR_CTRL);
    wire  hit_stat  = (WB_ADR_I == SPBT_ADDR_STATUS);
    wire  ctrl_wr   = bus_req & WB_WE_I & hit_ctrl & WB_SEL_I[0];

    wire spbt_mode_e ob_mode = spbt_decode(ctrl_q[CTRL_OB_HI], ctrl_q[CTRL_OB_LO]);
    wire spbt_mode_e ib_mode = spbt_decode(ctrl_q[CTRL_IB_HI], ctrl_q[CTRL_IB_LO]);
    wire ret_sel   = ctrl_q[CTRL_RETURN];
    wire local_en  = ctrl_q[CTRL_LOCAL_EN];
    wire bp_active = ctrl_q[CTRL_BP_EN_HIGH] & ~ctrl_q[CTRL_BP_EN_LOW];

    // Logic elements
    logic [WIDTH-1:0] ob_q, ib_q;
    wire  og_rise = og_v_q & ~og_prev_q;
    wire  ig_rise = ig_v_q & ~ig_prev_q;
    wire  ig_fall = ~ig_v_q & ig_prev_q;

    // Element output before inversion: buffer and open latch pass data
    function automatic logic [WIDTH-1:0] elem_out(input spbt_mode_e m, input logic [WIDTH-1:0] d,
                                                  input logic g, input logic [WIDTH-1:0] q);
        logic [WIDTH-1:0] r;
        r = q;
        if (m == SPBT_BUFFER || (m == SPBT_LATCH && g)) begin
            r = d;
        end
        return r;
    endfunction

    function automatic logic [WIDTH-1:0] elem_next(input spbt_mode_e m, input logic [WIDTH-1:0] d,
                                                   input logic g, input logic rise,
                                                   input logic [WIDTH-1:0] q);
        logic [WIDTH-1:0] r;
        r = q;
        case (m)
            SPBT_FLOP:   if (rise) r = d;
            SPBT_LATCH:  if (g) r = d;
            default:     r = q;
        endcase
        return r;
    endfunction

    wire [WIDTH-1:0] ob_p = elem_out(ob_mode, ai_v_q, og_v_q, ob_q);
    wire [WIDTH-1:0] ib_d = ret_sel ? ob_p : bp_v_q;
    wire [WIDTH-1:0] ib_p = elem_out(ib_mode, ib_d, ig_v_q, ib_q);

    // Elements run regardless of output enables
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ob_q <= '0;
            ib_q <= '0;
        end else begin
            ob_q <= elem_next(ob_mode, ai_v_q, og_v_q, og_rise, ob_q);
            ib_q <= elem_next(ib_mode, ib_d, ig_v_q, ig_rise, ib_q);
        end
    end

    // Port drivers, registered
    logic [WIDTH-1:0] local_out_q, local_oe_n_q, bp_oe_n_q;
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            local_out_q  <= '0;
            local_oe_n_q <= '1;
            bp_oe_n_q    <= '1;
        end else begin
            local_out_q  <= ~ib_p;
            local_oe_n_q <= {WIDTH{~local_en}};
            bp_oe_n_q    <= bp_active ? ~ob_p : {WIDTH{1'b1}};
        end
    end
    assign LOCAL_OUT_BUS  = local_out_q;
    assign LOCAL_OUT_OE_N = local_oe_n_q;
    assign BACKPLANE_O    = '0;
    assign BACKPLANE_OE_N = bp_oe_n_q;

    // Two-entry capture buffer for inbound stored words
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q, rd_ptr_q;
    logic [PW:0]      count_q;
    wire  cap_evt = (ib_mode == SPBT_FLOP && ig_rise) || (ib_mode == SPBT_LATCH && ig_fall);
    wire  full    = (count_q == (PW+1)'(DEPTH));
    wire  empty   = (count_q == '0);
    wire  push    = cap_evt & ~full;
    wire  pop     = CAPTURE_READY & ~empty;
    wire [WIDTH-1:0] cap_word = ~elem_next(ib_mode, ib_d, ig_v_q, ig_rise, ib_q);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= cap_word;
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
    assign CAPTURE_IN_READY = ~full;
    assign CAPTURE_VALID    = ~empty;
    assign CAPTURE_DATA     = empty ? '0 : mem_q[rd_ptr_q];

    // Wishbone slave, one wait state
    logic [SPBT_WB_DW-1:0] rdata_q;
    wire  [SPBT_WB_DW-1:0] status_w = (SPBT_WB_DW'(ob_p) << STAT_OB_LSB) | (SPBT_WB_DW'(ib_p) << STAT_IB_LSB)
                                    | (SPBT_WB_DW'(full) << STAT_FULL) | (SPBT_WB_DW'(empty) << STAT_EMPTY);
    wire  [SPBT_WB_DW-1:0] rd_sel   = hit_ctrl ? SPBT_WB_DW'(ctrl_q) : (hit_stat ? status_w : '0);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ctrl_q  <= CTRL_RESET;
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q   <= bus_req;
            rdata_q <= (bus_req & ~WB_WE_I) ? rd_sel : '0;
            if (ctrl_wr) ctrl_q <= WB_DAT_I[CTRL_W-1:0];
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

    // Checks
    property p_buffer_out;
        @(posedge MCLK) disable iff (!RST_N)
        (ob_mode == SPBT_BUFFER && bp_active) |=> (BACKPLANE_OE_N == ~$past(ai_v_q));
    endproperty
    a_buffer_out: assert property (p_buffer_out) else $error("buffer mode output wrong");

    property p_flop_capture;
        @(posedge MCLK) disable iff (!RST_N)
        (ob_mode == SPBT_FLOP && og_rise) |=> (ob_q == $past(ai_v_q));
    endproperty
    a_flop_capture: assert property (p_flop_capture) else $error("flop missed rising edge");

    property p_flop_hold;
        @(posedge MCLK) disable iff (!RST_N)
        (ob_mode == SPBT_FLOP && !og_rise && $stable(ctrl_q)) |=> $stable(ob_q);
    endproperty
    a_flop_hold: assert property (p_flop_hold) else $error("flop changed without edge");

    property p_latch_hold;
        @(posedge MCLK) disable iff (!RST_N)
        (ib_mode == SPBT_LATCH && !ig_v_q) |=> (ib_q == $past(ib_q));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed");

    property p_return_path;
        @(posedge MCLK) disable iff (!RST_N)
        (ib_mode == SPBT_BUFFER) |=> (LOCAL_OUT_BUS == ~($past(ret_sel) ? $past(ob_p) : $past(bp_v_q)));
    endproperty
    a_return_path: assert property (p_return_path) else $error("inbound source wrong");

    property p_local_enable;
        @(posedge MCLK) disable iff (!RST_N)
        $changed(local_en) |=> (LOCAL_OUT_OE_N == {WIDTH{~$past(local_en)}});
    endproperty
    a_local_enable: assert property (p_local_enable) else $error("local enable wrong");

    property p_bp_inactive;
        @(posedge MCLK) disable iff (!RST_N)
        (!ctrl_q[CTRL_BP_EN_HIGH] || ctrl_q[CTRL_BP_EN_LOW]) |=> (&BACKPLANE_OE_N);
    endproperty
    a_bp_inactive: assert property (p_bp_inactive) else $error("backplane driven while inactive");

    property p_wb_ack;
        @(posedge MCLK) disable iff (!RST_N)
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack timing wrong");

    property p_bp_drive;
        @(posedge MCLK) disable iff (!RST_N)
        bp_active |=> (BACKPLANE_OE_N == ~$past(ob_p));
    endproperty
    a_bp_drive: assert property (p_bp_drive) else $error("active backplane shows wrong level");

    property p_latch_open;
        @(posedge MCLK) disable iff (!RST_N)
        (ob_mode == SPBT_LATCH && og_v_q) |=> (ob_q == $past(ai_v_q));
    endproperty
    a_latch_open: assert property (p_latch_open) else $error("open latch did not follow data");

    property p_inbound_flop;
        @(posedge MCLK) disable iff (!RST_N)
        (ib_mode == SPBT_FLOP && ig_rise) |=> (ib_q == $past(ib_d));
    endproperty
    a_inbound_flop: assert property (p_inbound_flop) else $error("inbound flop missed its source");

    property p_local_drive;
        @(posedge MCLK) disable iff (!RST_N)
        local_en |=> (LOCAL_OUT_OE_N == '0 && LOCAL_OUT_BUS == ~$past(ib_p));
    endproperty
    a_local_drive: assert property (p_local_drive) else $error("local bus not driven with inverse");

    property p_reset_idle;
        @(posedge MCLK)
        !RST_N |=> (&BACKPLANE_OE_N && &LOCAL_OUT_OE_N && !WB_ACK_O && !CAPTURE_VALID);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");

    property p_capture_hold;
        @(posedge MCLK) disable iff (!RST_N)
        (CAPTURE_VALID && !CAPTURE_READY) |=> (CAPTURE_VALID && $stable(CAPTURE_DATA));
    endproperty
    a_capture_hold: assert property (p_capture_hold) else $error("capture word lost while stalled");

    property p_capture_full;
        @(posedge MCLK) disable iff (!RST_N)
        (full && !CAPTURE_READY) |=> !CAPTURE_IN_READY;
    endproperty
    a_capture_full: assert property (p_capture_full) else $error("full buffer shows ready");

    property p_wb_idle_zero;
        @(posedge MCLK) disable iff (!RST_N)
        !WB_ACK_O |-> (WB_DAT_O == '0);
    endproperty
    a_wb_idle_zero: assert property (p_wb_idle_zero) else $error("read data not zero without ack");

endmodule // spbt_top

// >>> spbt_partner.sv
// Far side model: open-collector backplane line and local output pins
`timescale 1ns/1ps
module spbt_partner (
    input  wire logic       MCLK,
    input  wire logic [7:0] REMOTE_PULL_N,
    input  wire logic [7:0] BP_OE_N,
    input  wire logic [7:0] LOC_OUT,
    input  wire logic [7:0] LOC_OE_N,
    output logic      [7:0] BP_LINE,
    output logic      [7:0] LOC_PIN
);
    logic [7:0] last_q = 8'h00;
    // Wired-AND line with pull-up, any driver pulls low
    assign BP_LINE = REMOTE_PULL_N & BP_OE_N;
    // Floating local bus shows the inverse of its last level
    assign LOC_PIN = (LOC_OE_N == 8'h00) ? LOC_OUT : ~last_q;
    always_ff @(posedge MCLK) begin
        if (LOC_OE_N == 8'h00) begin
            last_q <= LOC_OUT;
        end
    end
endmodule // spbt_partner

// >>> spbt_top_bench.sv
// Self-checking bench for the split-port backplane transceiver
`timescale 1ns/1ps
module spbt_top_bench;
    import spbt_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat_w = 32'h00000000;
    logic [31:0] dat_r;
    logic [31:0] rd;
    logic        ack;
    logic [7:0]  ain = 8'h00;
    logic [7:0]  rem = 8'hFF;
    logic        ogate = 1'b0;
    logic        igate = 1'b0;
    logic        crdy = 1'b0;
    logic [7:0]  aout, aoe_n, bpo, bpoe_n, line, lpin, cdata, v1, v2;
    logic [7:0]  wq [3];
    logic [31:0] ex;
    logic        cirdy, cvalid;
    int          bad_count = 0;
    int          checks = 0;
    int          seed = 75;

    initial begin
        forever #4 mclk = ~mclk;
    end

    spbt_top u_dut (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .LOCAL_IN_BUS(ain), .LOCAL_OUT_BUS(aout), .LOCAL_OUT_OE_N(aoe_n), .BACKPLANE_I(line),
        .BACKPLANE_O(bpo), .BACKPLANE_OE_N(bpoe_n), .OUTBOUND_CLOCK_GATE(ogate),
        .INBOUND_CLOCK_GATE(igate), .CAPTURE_IN_READY(cirdy), .CAPTURE_VALID(cvalid),
        .CAPTURE_READY(crdy), .CAPTURE_DATA(cdata));

    spbt_partner u_far (.MCLK(mclk), .REMOTE_PULL_N(rem), .BP_OE_N(bpoe_n), .LOC_OUT(aout),
        .LOC_OE_N(aoe_n), .BP_LINE(line), .LOC_PIN(lpin));

    function automatic logic [7:0] rnd();
        int t;
        t = $random(seed);
        return t[7:0];
    endfunction

    // Expected status word: element outputs before inversion, full and empty flags
    function automatic logic [31:0] status_exp(input logic [7:0] ob, input logic [7:0] ib,
                                               input logic f, input logic e);
        return {14'h0000, e, f, ib, ob};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            bad_count++;
            summarize();
        end
    endtask

    // Data held steady before the gate pulse, gate held well past sync depth
    task automatic pulse(input logic ob);
        repeat (5) @(posedge mclk);
        if (ob) ogate <= 1'b1;
        else igate <= 1'b1;
        repeat (5) @(posedge mclk);
        ogate <= 1'b0;
        igate <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask

    task automatic settle();
        repeat (12) @(posedge mclk);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        chk(bpoe_n, 8'hFF);
        chk(aoe_n, 8'hFF);
        chk(bpo, 8'h00);
        wb(1'b0, SPBT_ADDR_CTRL, 8'h00);
        chk(rd[7:0], 8'h80);
        wb(1'b0, 4'h8, 8'h00);
        chk(rd[7:0], 8'h00);
        ain <= 8'hFF;
        for (int e = 0; e < 4; e++) begin
            wb(1'b1, SPBT_ADDR_CTRL, {e[1], e[0], 6'h20});
            settle();
            chk(line, (e == 1) ? 8'h00 : 8'hFF);
            chk(aoe_n, 8'h00);
        end
        wb(1'b1, SPBT_ADDR_CTRL, 8'h60);
        for (int i = 0; i < 6; i++) begin
            ain <= rnd();
            settle();
            chk(line, ~ain);
            chk(lpin, ~line);
        end
        wb(1'b1, SPBT_ADDR_CTRL, 8'h61);
        v1 = rnd();
        v2 = ~v1;
        ain <= v1;
        pulse(1'b1);
        chk(line, ~v1);
        ain <= v2;
        settle();
        chk(line, ~v1);
        wb(1'b1, SPBT_ADDR_CTRL, 8'h21);
        pulse(1'b1);
        chk(line, 8'hFF);
        wb(1'b1, SPBT_ADDR_CTRL, 8'h61);
        settle();
        chk(line, ~v2);
        wb(1'b1, SPBT_ADDR_CTRL, 8'h62);
        ogate <= 1'b1;
        settle();
        chk(line, ~v2);
        ain <= v1;
        settle();
        chk(line, ~v1);
        ogate <= 1'b0;
        settle();
        ain <= v2;
        settle();
        chk(line, ~v1);
        wb(1'b1, SPBT_ADDR_CTRL, 8'h30);
        rem <= rnd();
        settle();
        chk(lpin, ~v2);
        wb(1'b1, SPBT_ADDR_CTRL, 8'h20);
        settle();
        chk(lpin, ~rem);
        wb(1'b1, SPBT_ADDR_CTRL, 8'h04);
        for (int k = 0; k < 3; k++) begin
            wq[k] = rnd();
            rem <= wq[k];
            pulse(1'b0);
        end
        chk({7'h00, cirdy}, 8'h00);
        chk({7'h00, cvalid}, 8'h01);
        for (int k = 0; k < 2; k++) begin
            chk(cdata, ~wq[k]);
            crdy <= 1'b1;
            @(posedge mclk);
            crdy <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        chk({7'h00, cvalid}, 8'h00);
        wb(1'b1, SPBT_ADDR_CTRL, 8'h08);
        rem <= v1;
        pulse(1'b0);
        rem <= v2;
        settle();
        wb(1'b0, SPBT_ADDR_STATUS, 8'h00);
        ex = status_exp(v2, v1, 1'b0, 1'b0);
        chk(rd[7:0], ex[7:0]);
        chk(rd[15:8], ex[15:8]);
        chk({6'h00, rd[17:16]}, {6'h00, ex[17:16]});
        chk(cdata, ~v1);
        crdy <= 1'b1;
        @(posedge mclk);
        crdy <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({7'h00, cvalid}, 8'h00);
        summarize();
    end
endmodule // spbt_top_bench
